// ===== matcher_model.sv
// Purpose: external address matcher on the far side of the match port
// Assumes: byte clock; matcher bus lags the receive bus by one cycle
// Notes: match held until its cycle counter saturates or the next destination phase starts
`timescale 1ns/1ps
`default_nettype none
module matcher_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic phase,
  input wire logic [9:0] rx,
  input wire logic [47:0] addr,
  input wire logic [3:0] dly,
  output logic match
);
  logic phase_r;
  logic [4:0] cnt_r;
  logic [47:0] got_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
      cnt_r <= 5'h1F;
      got_r <= 48'h0;
    end else begin
      phase_r <= phase;
      if (phase && !phase_r) begin
        cnt_r <= 5'h0;
      end else if (cnt_r != 5'h1F) begin
        cnt_r <= cnt_r + 5'h1;
      end
      if (cnt_r < 5'h6) begin
        got_r <= {got_r[39:0], rx[8:5], rx[3:0]};
      end
    end
  end
  // answer inside window; dropped at a new phase so it never leaks
  assign match = !phase && cnt_r != 5'h1F && cnt_r >= 5'h6 + {1'b0, dly} && got_r == addr;
endmodule
`default_nettype wire

// ===== sym_pkg.sv
// Purpose: constants and types for the symbol-pair and address-match port
// Assumes: one byte clock domain (CLK)
// Notes: symbol codes are shared by receive and transmit buses
// Notes on behaviour
// - never send halt, quiet, violation or link-bad code on transmit bus
// - two one-way 10-bit buses, each split into two 5-bit symbols
// - bits 9..5 carry first symbol, bits 4..0 the second
// - data symbols 0..F are 0 followed by four binary bits
// - control symbols use fixed codes; link-bad code is all ones
// - both buses sampled and driven on the byte clock
// - matcher port: phase out, match and discard in, shared load/hit pin
// - address bytes offered to matcher as the core receives them
// - normal mode: one-cycle load strobe before destination and source
// - six address bytes follow strobe back to back, then a compare cycle
// - phase output rises with frame control, holds through last dest byte
// - token frame: phase output high for one or two cycles
// - late-match mode turns load pin into bridge-forward hit input
// - match sets A and wins over bridge-forward hit
// - discard at any time flushes frame and fixes C status; code misses a discard that comes with the end delimiter
// - station match sets A, sets C if copied, flush-clear may reset C
// - promiscuous mode repeats received A and C unchanged
// - bridge hit repeats A; sets C only if A was reset and copied
// - flush-clear mode clears C for flushed station frames; code does so only if received A is reset
`default_nettype none
package sym_pkg;
  localparam int SYM_W = 5;
  localparam int PAIR_W = 10;
  localparam int ADDR_BYTES = 6;
  localparam logic [4:0] SYM_H = 5'h14;
  localparam logic [4:0] SYM_I = 5'h17;
  localparam logic [4:0] SYM_J = 5'h1C;
  localparam logic [4:0] SYM_K = 5'h13;
  localparam logic [4:0] SYM_Q = 5'h10;
  localparam logic [4:0] SYM_R = 5'h11;
  localparam logic [4:0] SYM_S = 5'h19;
  localparam logic [4:0] SYM_T = 5'h1D;
  localparam logic [4:0] SYM_V = 5'h18;
  localparam logic [4:0] LINK_BAD_CODE = 5'h1F;
  localparam logic [3:0] TOKEN_FC_HI = 4'h8;
  localparam logic [3:0] TOKEN_FC_LO = 4'h0;
  localparam logic [3:0] TOKEN_FC_MASK_HI = 4'hB;

  typedef struct packed {
    logic [4:0] first;
    logic [4:0] second;
  } sym_pair_t;

  typedef struct packed {
    logic valid;
    sym_pair_t pair;
  } tx_word_t;

  typedef struct packed {
    logic a;
    logic c;
  } ac_t;

  typedef enum logic [1:0] {
    FN_STATION,
    FN_PROMISC,
    FN_BRIDGE
  } frame_fn_t;

  // data codes carry a zero top bit
  function automatic logic is_data(input logic [4:0] s);
    return s[4] == 1'b0;
  endfunction

  // symbols the MAC may not send
  function automatic logic is_forbidden(input logic [4:0] s);
    return (s == SYM_H) || (s == SYM_Q) || (s == SYM_V) || (s == LINK_BAD_CODE);
  endfunction
endpackage
`default_nettype wire

// ===== sym_port.sv
// Purpose: receive/transmit symbol-pair port and external address-match port
// Assumes: all matcher and physical-side signals are on the byte clock (CLK)
// Notes: transmit words pass a two-entry buffer; forbidden symbols become I
`timescale 1ns/1ps
`default_nettype none
module sym_port
  import sym_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [9:0] RX_SYMBOL_PAIR_BUS,
  output logic [9:0] MAC_RX_SYMBOL_BUS,
  input wire logic [9:0] TX_IN_DATA,
  input wire logic TX_IN_VALID,
  output logic TX_IN_READY,
  output logic [9:0] TX_SYMBOL_PAIR_BUS,
  output logic TX_OUT_VALID,
  input wire logic TX_OUT_READY,
  input wire logic LATE_MATCH_MODE,
  input wire logic FLUSH_CLEAR_MODE,
  input wire logic PROMISC_MODE,
  input wire logic AR_IN,
  input wire logic CR_IN,
  output logic DEST_PHASE_OUT,
  output logic ADDR_LOAD_STROBE_O,
  output logic ADDR_LOAD_STROBE_OE,
  input wire logic BRIDGE_FORWARD_HIT_I,
  input wire logic MATCH,
  input wire logic DISCARD,
  output logic FRAME_COPY,
  output logic FRAME_FLUSH,
  output logic STATUS_VALID,
  output logic A_OUT,
  output logic C_OUT
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_FC,
    S_DEST,
    S_SRC,
    S_BODY
  } rx_state_t;

  rx_state_t state_r;
  logic [3:0] cnt_r;
  logic [9:0] rx_r;
  logic matched_r;
  logic bridge_r;
  logic flushed_r;
  logic [3:0] win_r;
  logic [1:0] wr_ptr_r;
  logic [1:0] rd_ptr_r;
  tx_word_t buf_r [2];
  logic [9:0] tx_out_r;
  logic tx_out_valid_r;
  logic buf_full;
  logic buf_empty;
  logic [4:0] rx_first;
  logic [4:0] rx_second;
  logic start_del;
  logic end_del;
  logic is_token;
  logic bridge_hit;
  logic in_window;
  ac_t ac_nxt;

  assign rx_first = rx_r[9:5];
  assign rx_second = rx_r[4:0];
  assign start_del = (rx_first == SYM_J) && (rx_second == SYM_K);
  assign end_del = (rx_first == SYM_T) || (rx_second == SYM_T);
  assign is_token = ((rx_first[3:0] & TOKEN_FC_MASK_HI) == TOKEN_FC_HI)
      && (rx_second[3:0] == TOKEN_FC_LO) && is_data(rx_first);
  // shared pin is an input only in late-match mode
  assign bridge_hit = LATE_MATCH_MODE && BRIDGE_FORWARD_HIT_I;

  // receive bus sampled on the byte clock
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_r <= {SYM_I, SYM_I};
    end else begin
      rx_r <= RX_SYMBOL_PAIR_BUS;
    end
  end

  // core and matcher see the same byte
  assign MAC_RX_SYMBOL_BUS = rx_r;

  // frame position tracking
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (start_del) begin
            state_r <= S_FC;
          end
        end
        S_FC: begin
          cnt_r <= 4'h0;
          state_r <= is_token ? S_IDLE : S_DEST;
        end
        S_DEST: begin
          if (cnt_r == 4'(ADDR_BYTES - 1)) begin
            cnt_r <= 4'h0;
            state_r <= S_SRC;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_SRC: begin
          if (cnt_r == 4'(ADDR_BYTES - 1)) begin
            cnt_r <= 4'h0;
            state_r <= S_BODY;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_BODY: begin
          if (end_del || !is_data(rx_first)) begin
            state_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  // load strobe in the cycle before first dest and source byte
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ADDR_LOAD_STROBE_O <= 1'b0;
    end else begin
      ADDR_LOAD_STROBE_O <= !LATE_MATCH_MODE && ((state_r == S_IDLE && start_del)
          || (state_r == S_DEST && cnt_r == 4'(ADDR_BYTES - 2)));
    end
  end
  // pin driven only as a load strobe
  assign ADDR_LOAD_STROBE_OE = !LATE_MATCH_MODE;

  // phase high from frame control through last dest byte
  // token: frame control cycle plus one, never split by a gap
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DEST_PHASE_OUT <= 1'b0;
    end else begin
      DEST_PHASE_OUT <= (state_r == S_IDLE && start_del)
          || (state_r == S_FC)
          || (state_r == S_DEST && cnt_r != 4'(ADDR_BYTES - 1));
    end
  end

  // normal mode: answer window of eight edges after the strobe
  // late mode: second source byte up to end of frame
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      win_r <= 4'h0;
    end else if (ADDR_LOAD_STROBE_O) begin
      win_r <= 4'h8;
    end else if (win_r != 4'h0) begin
      win_r <= win_r - 4'h1;
    end
  end
  assign in_window = LATE_MATCH_MODE
      ? ((state_r == S_SRC && cnt_r != 4'h0) || state_r == S_BODY)
      : (win_r != 4'h0);

  // match over bridge hit; discard flushes anywhere in frame except in the end-delimiter cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      matched_r <= 1'b0;
      bridge_r <= 1'b0;
      flushed_r <= 1'b0;
    end else if (state_r == S_IDLE && start_del) begin
      matched_r <= 1'b0;
      bridge_r <= 1'b0;
      flushed_r <= DISCARD;
    end else begin
      if (in_window && MATCH) begin
        matched_r <= 1'b1;
      end
      if (in_window && bridge_hit && !MATCH) begin
        bridge_r <= 1'b1;
      end
      if (DISCARD && state_r != S_IDLE) begin
        flushed_r <= 1'b1;
      end
    end
  end

  // status bits for frame end
  always_comb begin
    ac_nxt.a = AR_IN;
    ac_nxt.c = CR_IN;
    if (PROMISC_MODE) begin
      ac_nxt.a = AR_IN;
      ac_nxt.c = CR_IN;
    end else if (matched_r) begin
      ac_nxt.a = 1'b1;
      if (!flushed_r) begin
        ac_nxt.c = 1'b1;
      end else if (FLUSH_CLEAR_MODE && !AR_IN) begin
        ac_nxt.c = 1'b0;
      end
    end else if (bridge_r) begin
      ac_nxt.a = AR_IN;
      ac_nxt.c = (!AR_IN && !flushed_r) ? 1'b1 : CR_IN;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      STATUS_VALID <= 1'b0;
      A_OUT <= 1'b0;
      C_OUT <= 1'b0;
      FRAME_COPY <= 1'b0;
      FRAME_FLUSH <= 1'b0;
    end else begin
      STATUS_VALID <= (state_r == S_BODY) && end_del;
      if ((state_r == S_BODY) && end_del) begin
        A_OUT <= ac_nxt.a;
        C_OUT <= ac_nxt.c;
      end
      FRAME_COPY <= (state_r == S_BODY) && end_del && !flushed_r
          && (matched_r || bridge_r || PROMISC_MODE);
      FRAME_FLUSH <= (state_r == S_BODY) && end_del && flushed_r;
    end
  end

  assign buf_full = (wr_ptr_r[1] != rd_ptr_r[1]) && (wr_ptr_r[0] == rd_ptr_r[0]);
  assign buf_empty = (wr_ptr_r == rd_ptr_r);
  assign TX_IN_READY = !buf_full;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_ptr_r <= 2'h0;
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end else if (TX_IN_VALID && !buf_full) begin
      buf_r[wr_ptr_r[0]] <= {1'b1,
          is_forbidden(TX_IN_DATA[9:5]) ? SYM_I : TX_IN_DATA[9:5],
          is_forbidden(TX_IN_DATA[4:0]) ? SYM_I : TX_IN_DATA[4:0]};
      wr_ptr_r <= wr_ptr_r + 2'h1;
    end
  end

  // transmit bus driven from a register on the byte clock
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_ptr_r <= 2'h0;
      tx_out_r <= {SYM_I, SYM_I};
      tx_out_valid_r <= 1'b0;
    end else if (!tx_out_valid_r || TX_OUT_READY) begin
      tx_out_valid_r <= !buf_empty;
      if (!buf_empty) begin
        tx_out_r <= buf_r[rd_ptr_r[0]].pair;
        rd_ptr_r <= rd_ptr_r + 2'h1;
      end
    end
  end
  assign TX_SYMBOL_PAIR_BUS = tx_out_r;
  assign TX_OUT_VALID = tx_out_valid_r;
endmodule
`default_nettype wire

// ===== sym_port_properties.sv
// Purpose: timing checks on the symbol and address-match port
// Assumes: one byte clock, reset active high
// Notes: token frames are told apart by the frame control byte
`timescale 1ns/1ps
`default_nettype none
module sym_port_checker
  import sym_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [9:0] RX_SYMBOL_PAIR_BUS,
  input wire logic [9:0] MAC_RX_SYMBOL_BUS,
  input wire logic [9:0] TX_SYMBOL_PAIR_BUS,
  input wire logic TX_OUT_VALID,
  input wire logic LATE_MATCH_MODE,
  input wire logic DEST_PHASE_OUT,
  input wire logic ADDR_LOAD_STROBE_O,
  input wire logic ADDR_LOAD_STROBE_OE,
  input wire logic FRAME_COPY,
  input wire logic FRAME_FLUSH,
  input wire logic STATUS_VALID,
  input wire logic A_OUT,
  input wire logic C_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic tok;
  logic bad_tx;
  logic [4:0] f;
  logic [4:0] s;
  assign f = TX_SYMBOL_PAIR_BUS[9:5];
  assign s = TX_SYMBOL_PAIR_BUS[4:0];
  assign bad_tx = (f inside {SYM_H, SYM_Q, SYM_V, 5'h1F})
      || (s inside {SYM_H, SYM_Q, SYM_V, 5'h1F});
  assign tok = ((MAC_RX_SYMBOL_BUS[8:5] & 4'hB) == 4'h8) && (MAC_RX_SYMBOL_BUS[3:0] == 4'h0);
  property p_tx_clean;
    TX_OUT_VALID |-> !bad_tx;
  endproperty
  a_tx_clean: assert property (p_tx_clean) else $error("forbidden transmit symbol");
  property p_rx_copy;
    !$past(RST) |-> MAC_RX_SYMBOL_BUS == $past(RX_SYMBOL_PAIR_BUS);
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("matcher bus lost a pair");
  property p_jk_strobe;
    !LATE_MATCH_MODE && MAC_RX_SYMBOL_BUS == {SYM_J, SYM_K}
        |=> ADDR_LOAD_STROBE_O && DEST_PHASE_OUT;
  endproperty
  a_jk_strobe: assert property (p_jk_strobe) else $error("no strobe after start");
  property p_sa_strobe;
    $rose(DEST_PHASE_OUT) && !tok && !LATE_MATCH_MODE |-> ##6 ADDR_LOAD_STROBE_O;
  endproperty
  a_sa_strobe: assert property (p_sa_strobe) else $error("source strobe misplaced");
  property p_phase_len;
    $rose(DEST_PHASE_OUT) && !tok |-> DEST_PHASE_OUT [*7] ##1 !DEST_PHASE_OUT;
  endproperty
  a_phase_len: assert property (p_phase_len) else $error("phase length wrong");
  property p_token_len;
    $rose(DEST_PHASE_OUT) && tok |-> DEST_PHASE_OUT [*2] ##1 !DEST_PHASE_OUT;
  endproperty
  a_token_len: assert property (p_token_len) else $error("token phase length wrong");
  property p_pin_dir;
    ADDR_LOAD_STROBE_OE == !LATE_MATCH_MODE && (LATE_MATCH_MODE -> !ADDR_LOAD_STROBE_O);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("shared pin direction wrong");
  property p_flush;
    FRAME_FLUSH |-> STATUS_VALID && !FRAME_COPY;
  endproperty
  a_flush: assert property (p_flush) else $error("flushed frame also copied");
  property p_ac_hold;
    !STATUS_VALID |-> $stable({A_OUT, C_OUT}) ##1 !(STATUS_VALID && $past(STATUS_VALID));
  endproperty
  a_ac_hold: assert property (p_ac_hold) else $error("status bits moved");
  c_copy: cover property (STATUS_VALID && FRAME_COPY);
  c_flush: cover property (FRAME_FLUSH);
  c_token: cover property ($rose(DEST_PHASE_OUT) && tok);
  c_late: cover property ($rose(DEST_PHASE_OUT) && LATE_MATCH_MODE);
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for the symbol and address-match port
// Assumes: inputs change on the falling edge
// Notes: status word compared as {copy, flush, A, C}
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sym_pkg::*;
  logic clk, rst, tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready, late, fclr, promisc;
  logic ar, cr, phase, strobe, oe, hit, match, discard, copy, flush, stat, a_out, c_out;
  logic [9:0] rx, mac_rx, tx_in, tx_out;
  logic [3:0] dly;
  logic [47:0] cam_addr = 48'h0123456789AB;
  int fails, checks_done;
  sym_port i_sym_port (.CLK(clk), .RST(rst), .RX_SYMBOL_PAIR_BUS(rx), .MAC_RX_SYMBOL_BUS(mac_rx),
    .TX_IN_DATA(tx_in), .TX_IN_VALID(tx_in_valid), .TX_IN_READY(tx_in_ready),
    .TX_SYMBOL_PAIR_BUS(tx_out), .TX_OUT_VALID(tx_out_valid), .TX_OUT_READY(tx_out_ready),
    .LATE_MATCH_MODE(late), .FLUSH_CLEAR_MODE(fclr), .PROMISC_MODE(promisc), .AR_IN(ar),
    .CR_IN(cr), .DEST_PHASE_OUT(phase), .ADDR_LOAD_STROBE_O(strobe), .ADDR_LOAD_STROBE_OE(oe),
    .BRIDGE_FORWARD_HIT_I(hit), .MATCH(match), .DISCARD(discard), .FRAME_COPY(copy),
    .FRAME_FLUSH(flush), .STATUS_VALID(stat), .A_OUT(a_out), .C_OUT(c_out));
  matcher_model i_matcher_model (.clk(clk), .rst(rst), .phase(phase), .rx(mac_rx),
    .addr(cam_addr), .dly(dly), .match(match));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic step(input logic [9:0] v);
    @(negedge clk);
    rx = v;
  endtask
  // data nibble code; only listed codes are ever sent
  function automatic logic [9:0] byt(input logic [7:0] b);
    return {1'b0, b[7:4], 1'b0, b[3:0]};
  endfunction
  task automatic frame(input logic [47:0] da, input logic dis, input logic bh,
                       input logic [1:0] acr, input logic [3:0] exp);
    int n;
    step({SYM_J, SYM_K});
    ar = acr[1];
    cr = acr[0];
    step(byt(8'h50));
    for (int i = 5; i >= 0; i--) step(byt(da[i*8 +: 8]));
    for (int i = 0; i < 10; i++) begin
      step(byt(8'h5A));
      discard = dis && (i == 8);
      hit = bh && (i > 2);
    end
    step({SYM_T, SYM_R});
    hit = 1'b0;
    step({SYM_I, SYM_I});
    n = 0;
    while (stat !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (stat !== 1'b1) begin
      fails++;
      tally_and_finish();
    end else begin
      cmp("copy flush a c", {6'h0, exp}, {6'h0, copy, flush, a_out, c_out});
    end
  endtask
  task automatic sc_station;
    @(negedge clk);
    dly = 4'h0;
    frame(cam_addr, 1'b0, 1'b0, 2'b00, 4'hB);
    frame(48'h0, 1'b0, 1'b0, 2'b00, 4'h0);
    frame(cam_addr, 1'b1, 1'b0, 2'b01, 4'h7);
  endtask
  task automatic sc_flush_clear;
    @(negedge clk);
    fclr = 1'b1;
    frame(cam_addr, 1'b1, 1'b0, 2'b01, 4'h6);
    frame(cam_addr, 1'b1, 1'b0, 2'b11, 4'h7);
    fclr = 1'b0;
  endtask
  task automatic sc_promisc;
    @(negedge clk);
    promisc = 1'b1;
    frame(48'h0, 1'b1, 1'b0, 2'b10, 4'h6);
    promisc = 1'b0;
  endtask
  task automatic sc_bridge;
    @(negedge clk);
    late = 1'b1;
    dly = 4'h1;
    frame(48'h0, 1'b0, 1'b1, 2'b00, 4'h9);
    frame(48'h0, 1'b0, 1'b1, 2'b10, 4'hA);
    frame(cam_addr, 1'b0, 1'b1, 2'b00, 4'hB);
  endtask
  task automatic sc_token;
    for (int m = 0; m < 2; m++) begin
      step({SYM_J, SYM_K});
      late = m[0];
      step(byt(8'h80));
      step({SYM_T, SYM_R});
      cmp("token phase first", 10'h1, {9'h0, phase});
      step({SYM_I, SYM_I});
      cmp("token phase second", 10'h1, {9'h0, phase});
      repeat (4) @(negedge clk);
      cmp("phase idle", 10'h0, {9'h0, phase});
    end
  endtask
  task automatic sc_tx;
    logic [9:0] q[$];
    logic [9:0] v[4];
    logic [9:0] e[4];
    logic took;
    int i;
    v = '{{SYM_H, 5'h00}, {SYM_Q, SYM_V}, {LINK_BAD_CODE, SYM_J}, {5'h0F, SYM_T}};
    e = '{{SYM_I, 5'h00}, {SYM_I, SYM_I}, {SYM_I, SYM_J}, {5'h0F, SYM_T}};
    i = 0;
    took = 1'b0;
    for (int k = 0; k < 30; k++) begin
      @(negedge clk);
      i += took;
      tx_out_ready = (k > 10);
      tx_in_valid = (i < 4);
      tx_in = v[i[1:0]];
      #1;
      took = tx_in_valid && tx_in_ready;
      if (tx_out_valid && tx_out_ready) q.push_back(tx_out);
      if (k == 8) cmp("in ready when full", 10'h0, {9'h0, tx_in_ready});
    end
    cmp("tx words", 10'h4, 10'(q.size()));
    foreach (q[j]) cmp("tx word", e[j % 4], q[j]);
  endtask
  initial begin
    fails = 0;
    checks_done = 0;
    {rst, tx_in_valid, tx_out_ready, late, fclr, promisc, ar, cr, hit, discard} = 10'h200;
    rx = {SYM_I, SYM_I};
    tx_in = 10'h0;
    dly = 4'h0;
    repeat (3) @(posedge clk);
    cmp("rx reset", 10'h2F7, mac_rx);
    cmp("tx reset", 10'h2F7, tx_out);
    @(negedge clk);
    rst = 1'b0;
    sc_station();
    sc_flush_clear();
    sc_promisc();
    sc_bridge();
    sc_token();
    sc_tx();
    tally_and_finish();
  end
endmodule
bind sym_port sym_port_checker i_sym_port_checker (.CLK(CLK), .RST(RST),
  .RX_SYMBOL_PAIR_BUS(RX_SYMBOL_PAIR_BUS), .MAC_RX_SYMBOL_BUS(MAC_RX_SYMBOL_BUS),
  .TX_SYMBOL_PAIR_BUS(TX_SYMBOL_PAIR_BUS), .TX_OUT_VALID(TX_OUT_VALID),
  .LATE_MATCH_MODE(LATE_MATCH_MODE), .DEST_PHASE_OUT(DEST_PHASE_OUT),
  .ADDR_LOAD_STROBE_O(ADDR_LOAD_STROBE_O), .ADDR_LOAD_STROBE_OE(ADDR_LOAD_STROBE_OE),
  .FRAME_COPY(FRAME_COPY), .FRAME_FLUSH(FRAME_FLUSH), .STATUS_VALID(STATUS_VALID),
  .A_OUT(A_OUT), .C_OUT(C_OUT));
`default_nettype wire
